//--- pkg/bst_pkg.sv
// ****************************************************************
// Constants of the boundary-scan test port.
// ****************************************************************
package bst_pkg;

    // Scan register lengths and boundary cell index width.
    localparam int IR_W   = 8;
    localparam int BSR_W  = 121;
    localparam int ID_W   = 32;
    localparam int BSR_IW = 7;

    // Cell of the impedance calibration ball inside the boundary chain.
    localparam logic [BSR_IW-1:0] CAL_BSR_POS = 7'h3C;

    // Bit of mode register one that guards the calibration ball cell.
    localparam int MODE_REG_CAL_BIT = 7;

    // Value of the guarding bit after reset.
    localparam logic MODE_REG_CAL_RST = 1'h0;

    // Consecutive high samples of mode select that always reach reset.
    localparam int TMS_RESET_EDGES = 5;

    // Pattern loaded into the two low instruction bits at capture.
    localparam logic [1:0] IR_CAPTURE_LSB = 2'h1;

    // Instruction codes.
    localparam logic [IR_W-1:0] INS_EXTEST = 8'h00;
    localparam logic [IR_W-1:0] INS_IDCODE = 8'h01;
    localparam logic [IR_W-1:0] INS_SAMPLE = 8'h05;
    localparam logic [IR_W-1:0] INS_CLAMP  = 8'h07;
    localparam logic [IR_W-1:0] INS_HIGHZ  = 8'h03;
    localparam logic [IR_W-1:0] INS_BYPASS = 8'hFF;

    // Identification value; the value is arbitrary.
    localparam logic [ID_W-1:0] ID_VALUE = 32'h0A5A_5001;

    // Reset value of the bypass cell and synchroniser depth.
    localparam logic BYPASS_RST = 1'h0;
    localparam int   SYNC_STAGES = 2;

    // Controller states.
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
        ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
        ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } bst_state_t;

endpackage : bst_pkg

//--- rtl/bst_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Two-stage synchroniser for levels, with asynchronous reset.
// ****************************************************************
module bst_sync #(
    parameter int         W       = 1,
    parameter logic [0:0] RST_VAL = 1'h0
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= {W{RST_VAL}};
            q      <= {W{RST_VAL}};
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule : bst_sync
`default_nettype wire

//--- rtl/bst_tap.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Port logic runs on test clock, except the mode register bit and reset flag, which run on the main clock.
// - Mode select and data in are sampled on rising test clock.
// - Data out and its enable launch on falling test clock edge only.
// - State advances each rising edge; low takes 0 branch, high 1.
// - Instruction held in instruction register picks the scan path.
// - Instruction, boundary, bypass and identification registers exist.
// - Data in enters the most significant bit, shifting toward bit 0.
// - Data out comes from least significant bit of selected register.
// - Data out driven only in shift states, otherwise released.
// - Mode register one bit 7 is low after power-up.
// - Power-up starts in reset state without disturbing the memory.
// - Undriven mode select and data in read high.
// - Five high mode select edges force reset; high keeps it there.
// - Instruction capture loads 01 into the two low instruction bits.
// - Power-up and reset state load the identification instruction.
// - Boundary-scan register is 121 bits long.
module bst_tap (
    input  wire logic                      clk,
    input  wire logic                      resetn,
    input  wire logic                      tck,
    input  wire logic                      tms,
    input  wire logic                      tms_driven,
    input  wire logic                      tdi,
    input  wire logic                      tdi_driven,
    input  wire logic                      mode_reg_wr,
    input  wire logic                      mode_reg_cal_bit,
    input  wire logic [bst_pkg::BSR_W-1:0] ball_in,
    output var  logic                      tdo,
    output var  logic                      tdo_oe,
    output var  logic [bst_pkg::BSR_W-1:0] bsr_drive,
    output var  logic                      bsr_drive_en,
    output var  logic                      mode_reg_cal_r,
    output var  logic                      tap_in_reset
);

    // ************************************************************
    // Main clock domain: mode register bit and reset status.
    // ************************************************************

    logic mode_reg_cal_nxt;
    logic tap_reset_r;
    logic tap_reset_sync;

    // Software updates the guarding bit through a mode register write.
    assign mode_reg_cal_nxt = mode_reg_wr ? mode_reg_cal_bit : mode_reg_cal_r;

    // Holds the bit, low from power-up until a mode register write sets it.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_reg_cal_r <= bst_pkg::MODE_REG_CAL_RST;
        end else begin
            mode_reg_cal_r <= mode_reg_cal_nxt;
        end
    end

    // Brings the controller reset level into the main domain.
    bst_sync #(.W(1), .RST_VAL(1'h1)) u_rst_to_clk (
        .clk    (clk),
        .resetn (resetn),
        .d      (tap_reset_r),
        .q      (tap_reset_sync)
    );

    // Registered copy so the output comes straight from a flop.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tap_in_reset <= 1'h1;
        end else begin
            tap_in_reset <= tap_reset_sync;
        end
    end

    // ************************************************************
    // Test clock domain: reset release and crossings.
    // ************************************************************

    logic                      tck_rstn;
    logic                      cal_guard;
    logic [bst_pkg::BSR_W-1:0] ball_sync;

    // Releases the test logic cleanly on the test clock.
    bst_sync #(.W(1), .RST_VAL(1'h0)) u_tck_rst (
        .clk    (tck),
        .resetn (resetn),
        .d      (1'h1),
        .q      (tck_rstn)
    );

    // Mode register bit crosses as a level.
    bst_sync #(.W(1), .RST_VAL(1'h0)) u_cal_guard (
        .clk    (tck),
        .resetn (resetn),
        .d      (mode_reg_cal_r),
        .q      (cal_guard)
    );

    // Ball levels come from outside and pass two flops.
    bst_sync #(.W(bst_pkg::BSR_W), .RST_VAL(1'h0)) u_balls (
        .clk    (tck),
        .resetn (resetn),
        .d      (ball_in),
        .q      (ball_sync)
    );

    // ************************************************************
    // Controller state machine.
    // ************************************************************

    bst_pkg::bst_state_t state_r;
    bst_pkg::bst_state_t state_nxt;
    logic                tms_eff;
    logic                tdi_eff;

    // Undriven inputs read high like a pulled-up ball.
    assign tms_eff = tms_driven ? tms : 1'h1;
    assign tdi_eff = tdi_driven ? tdi : 1'h1;

    // Next state: a high mode select takes the 1 branch.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            bst_pkg::ST_RESET:
                state_nxt = tms_eff ? bst_pkg::ST_RESET
                                    : bst_pkg::ST_IDLE;
            bst_pkg::ST_IDLE:
                state_nxt = tms_eff ? bst_pkg::ST_SEL_DR
                                    : bst_pkg::ST_IDLE;
            bst_pkg::ST_SEL_DR:
                state_nxt = tms_eff ? bst_pkg::ST_SEL_IR
                                    : bst_pkg::ST_CAP_DR;
            bst_pkg::ST_CAP_DR, bst_pkg::ST_SHIFT_DR:
                state_nxt = tms_eff ? bst_pkg::ST_EXIT1_DR
                                    : bst_pkg::ST_SHIFT_DR;
            bst_pkg::ST_EXIT1_DR:
                state_nxt = tms_eff ? bst_pkg::ST_UPD_DR
                                    : bst_pkg::ST_PAUSE_DR;
            bst_pkg::ST_PAUSE_DR:
                state_nxt = tms_eff ? bst_pkg::ST_EXIT2_DR
                                    : bst_pkg::ST_PAUSE_DR;
            bst_pkg::ST_EXIT2_DR:
                state_nxt = tms_eff ? bst_pkg::ST_UPD_DR
                                    : bst_pkg::ST_SHIFT_DR;
            bst_pkg::ST_UPD_DR, bst_pkg::ST_UPD_IR:
                state_nxt = tms_eff ? bst_pkg::ST_SEL_DR
                                    : bst_pkg::ST_IDLE;
            bst_pkg::ST_SEL_IR:
                state_nxt = tms_eff ? bst_pkg::ST_RESET
                                    : bst_pkg::ST_CAP_IR;
            bst_pkg::ST_CAP_IR, bst_pkg::ST_SHIFT_IR:
                state_nxt = tms_eff ? bst_pkg::ST_EXIT1_IR
                                    : bst_pkg::ST_SHIFT_IR;
            bst_pkg::ST_EXIT1_IR:
                state_nxt = tms_eff ? bst_pkg::ST_UPD_IR
                                    : bst_pkg::ST_PAUSE_IR;
            bst_pkg::ST_PAUSE_IR:
                state_nxt = tms_eff ? bst_pkg::ST_EXIT2_IR
                                    : bst_pkg::ST_PAUSE_IR;
            bst_pkg::ST_EXIT2_IR:
                state_nxt = tms_eff ? bst_pkg::ST_UPD_IR
                                    : bst_pkg::ST_SHIFT_IR;
            default:
                state_nxt = bst_pkg::ST_RESET;
        endcase
    end

    // Advances on every rising test clock edge.
    always_ff @(posedge tck or negedge tck_rstn) begin
        if (!tck_rstn) begin
            state_r <= bst_pkg::ST_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Reset level handed to the main domain, taken from a flop on the
    // falling edge so that a state change cannot glitch the crossing.
    always_ff @(negedge tck or negedge tck_rstn) begin
        if (!tck_rstn) begin
            tap_reset_r <= 1'h1;
        end else begin
            tap_reset_r <= (state_r == bst_pkg::ST_RESET);
        end
    end

    // ************************************************************
    // Instruction register and path selection.
    // ************************************************************

    logic [bst_pkg::IR_W-1:0] ir_sh_r;
    logic [bst_pkg::IR_W-1:0] ir_r;
    logic                     sel_id;
    logic                     sel_bsr;
    logic                     drive_en_nxt;

    // The held instruction decides the data path.
    assign sel_id  = (ir_r == bst_pkg::INS_IDCODE);
    assign sel_bsr = (ir_r == bst_pkg::INS_EXTEST)
                   || (ir_r == bst_pkg::INS_SAMPLE);
    assign drive_en_nxt = (ir_r == bst_pkg::INS_EXTEST)
                        || (ir_r == bst_pkg::INS_CLAMP);

    // Instruction shift stage: capture pattern, then shift from the top.
    always_ff @(posedge tck or negedge tck_rstn) begin
        if (!tck_rstn) begin
            ir_sh_r <= bst_pkg::INS_IDCODE;
        end else if (state_r == bst_pkg::ST_CAP_IR) begin
            ir_sh_r <= {ir_r[bst_pkg::IR_W-1:2],
                        bst_pkg::IR_CAPTURE_LSB};
        end else if (state_r == bst_pkg::ST_SHIFT_IR) begin
            ir_sh_r <= {tdi_eff, ir_sh_r[bst_pkg::IR_W-1:1]};
        end
    end

    // Held instruction: identification after reset, new value on update.
    always_ff @(posedge tck or negedge tck_rstn) begin
        if (!tck_rstn) begin
            ir_r <= bst_pkg::INS_IDCODE;
        end else if (state_r == bst_pkg::ST_RESET) begin
            ir_r <= bst_pkg::INS_IDCODE;
        end else if (state_r == bst_pkg::ST_UPD_IR) begin
            ir_r <= ir_sh_r;
        end
    end

    // ************************************************************
    // Data registers: boundary, identification, bypass.
    // ************************************************************

    logic [bst_pkg::BSR_W-1:0] bsr_sh_r;
    logic [bst_pkg::BSR_W-1:0] bsr_cap;
    logic [bst_pkg::ID_W-1:0]  id_sh_r;
    logic                      byp_r;
    logic                      cap_dr;
    logic                      shf_dr;

    assign cap_dr = (state_r == bst_pkg::ST_CAP_DR);
    assign shf_dr = (state_r == bst_pkg::ST_SHIFT_DR);

    // Calibration ball cell reads zero while the mode bit is set.
    genvar gi;
    generate
        for (gi = 0; gi < bst_pkg::BSR_W; gi = gi + 1) begin : g_cap
            if (gi == int'(bst_pkg::CAL_BSR_POS)) begin : g_cal
                assign bsr_cap[gi] = ball_sync[gi] & ~cal_guard;
            end else begin : g_ball
                assign bsr_cap[gi] = ball_sync[gi];
            end
        end
    endgenerate

    // Boundary chain of 121 cells.
    always_ff @(posedge tck or negedge tck_rstn) begin
        if (!tck_rstn) begin
            bsr_sh_r <= '0;
        end else if (cap_dr && sel_bsr) begin
            bsr_sh_r <= bsr_cap;
        end else if (shf_dr && sel_bsr) begin
            bsr_sh_r <= {tdi_eff, bsr_sh_r[bst_pkg::BSR_W-1:1]};
        end
    end

    // Identification register loads its fixed value at capture.
    always_ff @(posedge tck or negedge tck_rstn) begin
        if (!tck_rstn) begin
            id_sh_r <= bst_pkg::ID_VALUE;
        end else if (cap_dr && sel_id) begin
            id_sh_r <= bst_pkg::ID_VALUE;
        end else if (shf_dr && sel_id) begin
            id_sh_r <= {tdi_eff, id_sh_r[bst_pkg::ID_W-1:1]};
        end
    end

    // Single bypass cell, cleared at capture.
    always_ff @(posedge tck or negedge tck_rstn) begin
        if (!tck_rstn) begin
            byp_r <= bst_pkg::BYPASS_RST;
        end else if (cap_dr && !sel_id && !sel_bsr) begin
            byp_r <= bst_pkg::BYPASS_RST;
        end else if (shf_dr && !sel_id && !sel_bsr) begin
            byp_r <= tdi_eff;
        end
    end

    // Parallel boundary values change only in update-DR; drive enable follows the held instruction.
    always_ff @(posedge tck or negedge tck_rstn) begin
        if (!tck_rstn) begin
            bsr_drive    <= '0;
            bsr_drive_en <= 1'h0;
        end else begin
            if (state_r == bst_pkg::ST_UPD_DR && sel_bsr) begin
                bsr_drive <= bsr_sh_r;
            end
            bsr_drive_en <= drive_en_nxt;
        end
    end

    // ************************************************************
    // Serial output, launched on the falling edge.
    // ************************************************************

    logic dr_lsb;
    logic tdo_nxt;
    logic tdo_oe_nxt;

    // Lowest bit of the path that the instruction picks.
    assign dr_lsb = sel_id  ? id_sh_r[0]
                  : sel_bsr ? bsr_sh_r[0]
                  : byp_r;
    assign tdo_nxt = (state_r == bst_pkg::ST_SHIFT_IR) ? ir_sh_r[0]
                   : dr_lsb;
    assign tdo_oe_nxt = (state_r == bst_pkg::ST_SHIFT_IR)
                      || (state_r == bst_pkg::ST_SHIFT_DR);

    // Output flops; enable is low from reset so the ball floats.
    always_ff @(negedge tck or negedge tck_rstn) begin
        if (!tck_rstn) begin
            tdo    <= 1'h0;
            tdo_oe <= 1'h0;
        end else begin
            tdo    <= tdo_nxt;
            tdo_oe <= tdo_oe_nxt;
        end
    end

endmodule : bst_tap
`default_nettype wire

//--- test/bst_tap_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Checker of the test port pins.
// ****************************************************************
module bst_tap_monitor (
    input wire logic clk,
    input wire logic resetn,
    input wire logic tck,
    input wire logic tms,
    input wire logic tms_driven,
    input wire logic tdi,
    input wire logic tdi_driven,
    input wire logic mode_reg_wr,
    input wire logic mode_reg_cal_bit,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic bsr_drive_en,
    input wire logic mode_reg_cal_r,
    input wire logic tap_in_reset
);
    // Next-state tables of the controller, four bits per state.
    localparam logic [63:0] NXT0 = 64'h1BDD_BBA1_4664_4311;
    localparam logic [63:0] NXT1 = 64'h2FEF_CC02_8785_5920;
    logic [3:0]       st_r;
    logic [1:0]       wait_r;
    logic [7:0]       ir_r;
    logic [7:0]       ins_r;
    logic [1:0]       rise_r;
    wire logic        tms_in = tms_driven ? tms : 1'h1;
    wire logic        tdi_in = tdi_driven ? tdi : 1'h1;
    wire logic [63:0] tbl    = tms_in ? NXT1 : NXT0;
    wire logic [3:0]  st_nxt = tbl[{st_r, 2'h0} +: 4];

    // Reference state, held instruction and outputs seen at rising tck.
    always_ff @(posedge tck or negedge resetn) begin
        if (!resetn) begin
            st_r   <= 4'h0;
            wait_r <= 2'h0;
            ir_r   <= 8'h00;
            ins_r  <= bst_pkg::INS_IDCODE;
            rise_r <= 2'h0;
        end else begin
            rise_r <= {tdo, tdo_oe};
            wait_r <= (wait_r == 2'h2) ? wait_r : wait_r + 2'h1;
            st_r   <= (wait_r == 2'h2) ? st_nxt : 4'h0;
            ir_r   <= (st_r == 4'hB) ? {tdi_in, ir_r[7:1]} : ir_r;
            ins_r  <= (st_r == 4'hF) ? ir_r :
                      (st_r == 4'h0) ? bst_pkg::INS_IDCODE : ins_r;
        end
    end

    AST_TDO_FALL:
    assert property (@(negedge tck) disable iff (!resetn)
        {tdo, tdo_oe} == rise_r) else $error("tdo moved on rising tck");
    AST_OE_SHIFT:
    assert property (@(posedge tck) disable iff (!resetn)
        tdo_oe == (st_r == 4'h4 || st_r == 4'hB)) else $error("bad tdo_oe");
    AST_RST_ENTER:
    assert property (@(posedge clk) disable iff (!resetn)
        $rose(st_r == 4'h0) |-> ##[1:10] tap_in_reset) else $error("no reset");
    AST_RST_LEAVE:
    assert property (@(posedge clk) disable iff (!resetn)
        $fell(st_r == 4'h0) |-> ##[1:10] !tap_in_reset) else $error("stuck");
    AST_MODE_WR:
    assert property (@(posedge clk) disable iff (!resetn) mode_reg_wr |=>
        mode_reg_cal_r == $past(mode_reg_cal_bit)) else $error("guard write");
    AST_MODE_HOLD:
    assert property (@(posedge clk) disable iff (!resetn) !mode_reg_wr |=>
        $stable(mode_reg_cal_r)) else $error("guard bit moved");
    AST_IR_CAP:
    assert property (@(posedge tck) disable iff (!resetn)
        st_r == 4'hA ##1 st_r == 4'hB |-> tdo == bst_pkg::IR_CAPTURE_LSB[0]
        ##1 (st_r != 4'hB || tdo == bst_pkg::IR_CAPTURE_LSB[1]))
        else $error("capture pattern");
    AST_ID_LSB:
    assert property (@(posedge tck) disable iff (!resetn)
        st_r == 4'h3 && ins_r == bst_pkg::INS_IDCODE ##1 st_r == 4'h4
        |-> tdo == bst_pkg::ID_VALUE[0]) else $error("id bit 0");
    AST_BYPASS:
    assert property (@(posedge tck) disable iff (!resetn) st_r == 4'h4 &&
        $past(st_r) == 4'h4 && ins_r == bst_pkg::INS_BYPASS |->
        tdo == $past(tdi_in)) else $error("bypass path");
    AST_BSR_EN:
    assert property (@(posedge tck) disable iff (!resetn) st_r == 4'h1 &&
        $past(st_r) == 4'h1 |-> bsr_drive_en == (ins_r ==
        bst_pkg::INS_EXTEST || ins_r == bst_pkg::INS_CLAMP)) else $error("en");
endmodule : bst_tap_monitor
`default_nettype wire

//--- test/bst_jtag_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Test controller model; tck stands low between its frames.
// ****************************************************************
module bst_jtag_host (
    output var  logic tck,
    output var  logic tms,
    output var  logic tms_driven,
    output var  logic tdi,
    output var  logic tdi_driven,
    input  wire logic tdo
);
    // Idle levels; released tdi keeps toggling so no stale level shows.
    initial begin
        tck        = 1'h0;
        tms        = 1'h1;
        tms_driven = 1'h1;
        tdi        = 1'h0;
        tdi_driven = 1'h0;
    end

    // One tck cycle: levels set while low, tdo taken at the rise.
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #6 tck = 1'h1;
        o = tdo;
        #6 tck = 1'h0;
    endtask : step

    // Five high samples; with drv low the ball floats and reads high.
    task automatic rst5(input logic drv);
        logic o;
        tms_driven = drv;
        repeat (5) step(drv, ~tdi, o);
        tms_driven = 1'h1;
    endtask : rst5

    // From idle through one scan of n bits, LSB first, back to idle.
    task automatic scan(input logic ir, input int n,
                        input  logic [bst_pkg::BSR_W-1:0] din,
                        output logic [bst_pkg::BSR_W-1:0] dout);
        logic o;
        dout = '0;
        tdi_driven = 1'h1;
        step(1'h1, ~tdi, o);
        if (ir) step(1'h1, ~tdi, o);
        step(1'h0, ~tdi, o);
        step(1'h0, ~tdi, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'h1, ~tdi, o);
        step(1'h0, ~tdi, o);
        tdi_driven = 1'h0;
    endtask : scan
endmodule : bst_jtag_host
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Self-checking bench of the boundary-scan test port.
// ****************************************************************
module tb;
    logic                      clk;
    logic                      resetn;
    logic                      mode_reg_wr;
    logic                      mode_reg_cal_bit;
    logic [bst_pkg::BSR_W-1:0] ball_in;
    logic [bst_pkg::BSR_W-1:0] bsr_drive;
    logic [bst_pkg::BSR_W-1:0] din;
    logic [bst_pkg::BSR_W-1:0] dout;
    logic [bst_pkg::BSR_W-1:0] exp_v;
    logic [127:0]              pat;
    logic [7:0]                codes [7];
    logic                      tck;
    logic                      tms;
    logic                      tms_driven;
    logic                      tdi;
    logic                      tdi_driven;
    logic                      tdo;
    logic                      tdo_oe;
    logic                      bsr_drive_en;
    logic                      mode_reg_cal_r;
    logic                      tap_in_reset;
    logic                      o;
    int                        n_fail;
    int                        n_checks;

    bst_tap       bst_tap_i (.*);
    bst_jtag_host bst_jtag_host_i (.*);

    // Main clock at 200 MHz.
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    // Compares one value and reports a mismatch.
    task automatic chk(input string what, input logic [120:0] e,
                       input logic [120:0] s);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, e, s);
        end
    endtask : chk

    // Waits a bounded time for the reset flag to reach a level.
    task automatic wait_rst(input logic e);
        for (int i = 0; i < 20 && tap_in_reset !== e; i++) begin
            @(posedge clk) #1;
        end
        chk("tap_in_reset", e, tap_in_reset);
        if (tap_in_reset !== e) tally_and_finish();
    endtask : wait_rst

    // Writes the calibration guard bit of mode register one.
    task automatic mode_wr(input logic b);
        @(posedge clk) #1;
        mode_reg_wr = 1'h1;
        mode_reg_cal_bit = b;
        @(posedge clk) #1;
        mode_reg_wr = 1'h0;
        chk("mode_reg_cal_r", b, mode_reg_cal_r);
    endtask : mode_wr

    // Reads the identification value from idle.
    task automatic t_id;
        bst_jtag_host_i.scan(1'h0, 32, '0, dout);
        chk("id", bst_pkg::ID_VALUE, dout[31:0]);
    endtask : t_id

    // Capture pattern of the instruction path and the bypass path.
    task automatic t_ir;
        bst_jtag_host_i.scan(1'h1, 8, bst_pkg::INS_BYPASS, dout);
        chk("ir", {bst_pkg::INS_IDCODE[7:2], 2'h1}, dout[7:0]);
        bst_jtag_host_i.scan(1'h0, 8, 'hA5, dout);
        chk("bypass", 8'h4A, dout[7:0]);
    endtask : t_ir

    // Snapshot of the balls with the guard bit set or clear, then drive.
    task automatic t_sample(input logic g);
        mode_wr(g);
        bst_jtag_host_i.scan(1'h1, 8, bst_pkg::INS_SAMPLE, dout);
        exp_v = ball_in;
        if (g) exp_v[bst_pkg::CAL_BSR_POS] = 1'h0;
        din = ~ball_in;
        bst_jtag_host_i.scan(1'h0, bst_pkg::BSR_W, din, dout);
        chk("boundary", exp_v, dout);
        bst_jtag_host_i.scan(1'h1, 8, bst_pkg::INS_EXTEST, dout);
        chk("bsr_drive", din, bsr_drive);
    endtask : t_sample

    // Every instruction code, one undefined; drive enable and bypass.
    task automatic t_codes;
        codes = '{bst_pkg::INS_EXTEST, bst_pkg::INS_IDCODE,
                  bst_pkg::INS_SAMPLE, bst_pkg::INS_CLAMP,
                  bst_pkg::INS_HIGHZ, bst_pkg::INS_BYPASS, 8'h42};
        foreach (codes[i]) begin
            bst_jtag_host_i.scan(1'h1, 8, codes[i], dout);
            repeat (2) bst_jtag_host_i.step(1'h0, ~tdi, o);
            chk("bsr_drive_en", codes[i] == bst_pkg::INS_EXTEST ||
                codes[i] == bst_pkg::INS_CLAMP, bsr_drive_en);
            if (i > 3) begin
                bst_jtag_host_i.scan(1'h0, 8, 'hA5, dout);
                chk("bypass", 8'h4A, dout[7:0]);
            end
        end
    endtask : t_codes

    // Main sequence.
    initial begin
        resetn = 1'h0;
        mode_reg_wr = 1'h0;
        mode_reg_cal_bit = 1'h0;
        ball_in = '0;
        n_fail = 0;
        n_checks = 0;
        fork
            begin
                repeat (2) @(posedge clk);
                #1 resetn = 1'h1;
            end
            #1 bst_jtag_host_i.step(1'h1, 1'h1, o);
        join
        chk("tap_in_reset", 1'h1, tap_in_reset);
        chk("guard", bst_pkg::MODE_REG_CAL_RST, mode_reg_cal_r);
        bst_jtag_host_i.rst5(1'h1);
        bst_jtag_host_i.step(1'h0, 1'h0, o);
        wait_rst(1'h0);
        t_id();
        t_ir();
        pat = {4{32'h96C3_A55A}};
        @(posedge clk) #1;
        ball_in = pat[bst_pkg::BSR_W-1:0];
        t_sample(1'h1);
        t_sample(1'h0);
        t_codes();
        bst_jtag_host_i.rst5(1'h0);
        wait_rst(1'h1);
        bst_jtag_host_i.step(1'h0, 1'h0, o);
        wait_rst(1'h0);
        t_id();
        tally_and_finish();
    end
endmodule : tb

bind bst_tap bst_tap_monitor bst_tap_monitor_i (.*);
`default_nettype wire
